// ==== logic/cshf_pkg.sv ====
// Constants shared by the coefficient store and horizontal filter
package cshf_pkg;
   localparam int PIX_W = 8;
   localparam int FIFO_W = 16;
   localparam int FIFO_DEPTH = 32;
   localparam int HL_DEPTH = 24;
   localparam int HC_DEPTH = 16;
   localparam int VL_DEPTH = 70;
   localparam int VC_DEPTH = 140;
   localparam logic [3:0] ADDR_HL = 4'h1;
   localparam logic [3:0] ADDR_HC = 4'h2;
   localparam logic [3:0] ADDR_VL = 4'h5;
   localparam logic [3:0] ADDR_VC = 4'h6;
   localparam logic [3:0] ADDR_CTRL0 = 4'h8;
   localparam logic [3:0] ADDR_CLR = 4'hF;
   localparam int CTRL_INTERP_BIT = 0;
   localparam int CTRL_NTSC_BIT = 1;
   localparam int CTRL_QCIF_BIT = 2;
   localparam logic [7:0] CTRL0_RESET = 8'h00;
   localparam logic [2:0] PINS_IDLE = 3'h7;
   localparam int PIN_CS = 2;
   localparam int PIN_WR = 1;
   localparam int PIN_RD = 0;
   localparam int TAPS_DEC_CIF = 8;
   localparam int TAPS_DEC_QCIF = 16;
   localparam int TAPS_MAX = 24;
   localparam int YSET = 6;
   localparam int CSET = 4;
   localparam logic [1:0] RLAST_CIF = 2'h1;
   localparam logic [1:0] RLAST_QCIF = 2'h3;
   localparam int COEF_SHIFT = 7;
   localparam int PIX_MAX = 255;
   localparam int VSET_CIF = 5;
   localparam int VSET_QCIF = 7;
   localparam int VL_EVEN_CIF = 1;
   localparam int VL_EVEN_QCIF = 2;
   localparam int VC_EVEN_CIF625 = 2;
   localparam int VC_EVEN_CIF525 = 5;
   localparam int VC_EVEN_QCIF625 = 4;
   localparam int VC_EVEN_QCIF525 = 10;
   localparam int VC_CIF525_ODD1 = 30;
   localparam int VC_CIF525_ODD2 = 40;
   typedef enum logic [0:0] {CSHF_ACCEPT = 1'b0, CSHF_EMIT = 1'b1} cshf_phase_t;
endpackage

// ==== logic/cshf_stream_if.sv ====
// Valid/ready word stream between filter and output buffer
interface cshf_stream_if #(parameter int W = 16) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ==== logic/cshf_fifo.sv ====
// Output word FIFO with honest full and empty
module cshf_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic reset,
   cshf_stream_if.snk wr,
   cshf_stream_if.src rd
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wptr;
      logic [PW-1:0] rptr;
      logic [CW-1:0] count;
   } cshf_fifo_state_t;
   cshf_fifo_state_t r;
   cshf_fifo_state_t n;
   logic push;
   logic pop;

   assign wr.ready = (r.count != CW'(DEPTH));
   assign rd.valid = (r.count != '0);
   assign rd.data = r.mem[r.rptr];
   assign push = wr.valid && wr.ready;
   assign pop = rd.valid && rd.ready;

   always_comb begin
      n = r;
      if (push) begin
         n.mem[r.wptr] = wr.data;
         n.wptr = (r.wptr == PW'(DEPTH - 1)) ? '0 : r.wptr + PW'(1);
      end
      if (pop) begin
         n.rptr = (r.rptr == PW'(DEPTH - 1)) ? '0 : r.rptr + PW'(1);
      end
      if (push && !pop) begin
         n.count = r.count + CW'(1);
      end else if (pop && !push) begin
         n.count = r.count - CW'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule // cshf_fifo

// ==== logic/cshf_top.sv ====
// Coefficient stores with host loading and polyphase horizontal filters
// Notes on behaviour
// - Sixteen-byte horizontal chroma store; each address 2 write fills next slot.
// - Horizontal chroma layout per mode: one decimation set, or four-coefficient phase sets.
// - Seventy-byte vertical luma store filled sequentially through address 5.
// - Vertical luma sets contiguous; interpolation odd-field set follows even set.
// - 140-byte vertical chroma store filled sequentially through address 6.
// - Vertical chroma sets of five or seven; even-field sets before odd.
// - Decimate luma and chroma by two for CIF, four for QCIF.
// - Decimation filters use 8 taps for CIF, 16 taps for QCIF.
// - Interpolating from CIF: luma 12 taps, each chroma channel 8 taps.
// - Interpolating from QCIF: luma 24 taps, each chroma channel 16 taps.
// - Interpolation emits two or four outputs per input, zeros implied between.
// - One polyphase set per clock; luma sets hold six coefficients each.
// - Write to address F clears all store counters; each access advances one.
// - Control bit 0 high selects interpolation, low selects decimation.
module cshf_top #(
   parameter int FIFO_DEPTH = cshf_pkg::FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [3:0] host_addr,
   input wire logic [cshf_pkg::PIX_W-1:0] host_data_in,
   output logic [cshf_pkg::PIX_W-1:0] host_data_out,
   output logic host_data_oe,
   input wire logic host_cs_n,
   input wire logic host_wr_n,
   input wire logic host_rd_n,
   input wire logic [cshf_pkg::PIX_W-1:0] in_y,
   input wire logic [cshf_pkg::PIX_W-1:0] in_c,
   input wire logic in_valid,
   output logic in_ready,
   output logic [cshf_pkg::PIX_W-1:0] out_y,
   output logic [cshf_pkg::PIX_W-1:0] out_c,
   output logic out_valid,
   input wire logic out_ready,
   input wire logic [4:0] vl_set,
   input wire logic vl_odd,
   input wire logic [2:0] vl_tap,
   output logic [cshf_pkg::PIX_W-1:0] vl_coef,
   input wire logic [4:0] vc_set,
   input wire logic vc_odd,
   input wire logic [2:0] vc_tap,
   output logic [cshf_pkg::PIX_W-1:0] vc_coef,
   output logic mode_interp,
   output logic mode_qcif
);
   import cshf_pkg::*;
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] pins;
      logic [7:0] ctrl0;
      logic [4:0] hl_cnt;
      logic [3:0] hc_cnt;
      logic [6:0] vl_cnt;
      logic [7:0] vc_cnt;
      logic [HL_DEPTH-1:0][7:0] hl;
      logic [HC_DEPTH-1:0][7:0] hc;
      logic [VL_DEPTH-1:0][7:0] vl;
      logic [VC_DEPTH-1:0][7:0] vc;
      logic [TAPS_MAX-1:0][7:0] yline;
      logic [HC_DEPTH-1:0][7:0] uline;
      logic [HC_DEPTH-1:0][7:0] vline;
      logic chan;
      logic last_ch;
      logic [1:0] phase;
      logic [1:0] emit_cnt;
      cshf_phase_t st;
      logic in_ready;
      logic [7:0] hd_out;
      logic hd_oe;
      logic [7:0] vl_coef;
      logic [7:0] vc_coef;
      logic out_valid;
      logic [FIFO_W-1:0] out_word;
   } cshf_state_t;
   localparam cshf_state_t ST_RESET = '{s1: PINS_IDLE, s2: PINS_IDLE, s3: PINS_IDLE,
      pins: PINS_IDLE, ctrl0: CTRL0_RESET, st: CSHF_ACCEPT, default: '0};
   cshf_state_t r;
   cshf_state_t n;
   cshf_stream_if #(.W(FIFO_W)) wr_if ();
   cshf_stream_if #(.W(FIFO_W)) rd_if ();
   cshf_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .reset(reset),
      .wr(wr_if),
      .rd(rd_if)
   );
   // Signed coefficients against unsigned pixels, clipped to pixel range
   function automatic logic [7:0] fir(input logic [TAPS_MAX-1:0][7:0] s,
                                      input logic [TAPS_MAX-1:0][7:0] c, input int taps);
      logic signed [23:0] acc;
      logic signed [23:0] q;
      acc = '0;
      for (int k = 0; k < TAPS_MAX; k++) begin
         if (k < taps) begin
            acc = acc + 24'($signed({1'b0, s[k]}) * $signed(c[k]));
         end
      end
      q = acc >>> COEF_SHIFT;
      if (q < 0) begin
         return 8'h00;
      end else if (q > PIX_MAX) begin
         return 8'hFF;
      end
      return q[7:0];
   endfunction
   function automatic int vl_index(input logic [4:0] set, input logic odd,
                                   input logic [2:0] tap, input logic qcif, input logic interp);
      int sz;
      int base;
      sz = qcif ? VSET_QCIF : VSET_CIF;
      base = (set == 5'h00) ? 0 : (int'(set) - 1) * sz;
      if (interp && odd) begin
         base = base + (qcif ? VL_EVEN_QCIF : VL_EVEN_CIF) * sz;
      end
      return base + int'(tap);
   endfunction
   function automatic int vc_index(input logic [4:0] set, input logic odd,
                                   input logic [2:0] tap, input logic qcif,
                                   input logic interp, input logic ntsc);
      int sz;
      int s;
      int base;
      int even;
      sz = qcif ? VSET_QCIF : VSET_CIF;
      s = (set == 5'h00) ? 0 : int'(set) - 1;
      base = s * sz;
      if (interp && odd) begin
         if (qcif) begin
            even = ntsc ? VC_EVEN_QCIF525 : VC_EVEN_QCIF625;
         end else begin
            even = ntsc ? VC_EVEN_CIF525 : VC_EVEN_CIF625;
         end
         base = (even + s) * sz;
         if (!qcif && ntsc) begin
            // Two five-byte gaps around odd set one
            base = (s == 0) ? VC_CIF525_ODD1 : VC_CIF525_ODD2 + (s - 1) * sz;
         end
      end
      return base + int'(tap);
   endfunction
   logic interp;
   logic qcif;
   logic ntsc;
   logic wr_start;
   logic rd_start;
   logic accept;
   logic [1:0] rlast;
   int ytaps;
   int ctaps;
   int vli;
   int vci;
   logic [TAPS_MAX-1:0][7:0] ycoef;
   logic [TAPS_MAX-1:0][7:0] ccoef;
   logic [TAPS_MAX-1:0][7:0] csamp;
   logic [2:0] pins_d;
   assign interp = r.ctrl0[CTRL_INTERP_BIT];
   assign qcif = r.ctrl0[CTRL_QCIF_BIT];
   assign ntsc = r.ctrl0[CTRL_NTSC_BIT];
   assign rlast = qcif ? RLAST_QCIF : RLAST_CIF;
   assign accept = (r.st == CSHF_ACCEPT) && in_valid && r.in_ready;
   // Strobe bit moves only once sync stages two and three agree
   assign pins_d = (r.s2 & r.s3) | (r.pins & (r.s2 ^ r.s3));
   // Address and data pins are only sampled once the strobe has settled
   assign wr_start = !pins_d[PIN_CS] && !pins_d[PIN_WR] && (r.pins[PIN_CS] || r.pins[PIN_WR]);
   assign rd_start = !pins_d[PIN_CS] && !pins_d[PIN_RD] && (r.pins[PIN_CS] || r.pins[PIN_RD]);
   // One polyphase set per output clock
   always_comb begin
      ycoef = '0;
      ccoef = '0;
      for (int k = 0; k < TAPS_MAX; k++) begin
         if (interp) begin
            if (k < YSET) begin
               ycoef[k] = r.hl[int'(r.emit_cnt) * YSET + k];
            end
            if (k < CSET) begin
               ccoef[k] = r.hc[int'(r.emit_cnt) * CSET + k];
            end
         end else begin
            if (k < HL_DEPTH) begin
               ycoef[k] = r.hl[k];
            end
            if (k < HC_DEPTH) begin
               ccoef[k] = r.hc[k];
            end
         end
      end
      if (interp) begin
         ytaps = YSET;
         ctaps = CSET;
      end else begin
         ytaps = qcif ? TAPS_DEC_QCIF : TAPS_DEC_CIF;
         ctaps = ytaps;
      end
      csamp = r.last_ch ? {{8{8'h00}}, r.vline} : {{8{8'h00}}, r.uline};
   end
   assign wr_if.valid = (r.st == CSHF_EMIT);
   assign wr_if.data = {fir(r.yline, ycoef, ytaps), fir(csamp, ccoef, ctaps)};
   assign rd_if.ready = !r.out_valid || out_ready;
   always_comb begin
      n = r;
      n.s1 = {host_cs_n, host_wr_n, host_rd_n};
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.pins = pins_d;
      vli = vl_index(vl_set, vl_odd, vl_tap, qcif, interp);
      vci = vc_index(vc_set, vc_odd, vc_tap, qcif, interp, ntsc);
      if (wr_start) begin
         case (host_addr)
            ADDR_HL: begin
               if (r.hl_cnt < HL_DEPTH) begin
                  n.hl[r.hl_cnt] = host_data_in;
               end
               n.hl_cnt = r.hl_cnt + 5'h01;
            end
            ADDR_HC: begin
               n.hc[r.hc_cnt] = host_data_in;
               n.hc_cnt = r.hc_cnt + 4'h1;
            end
            ADDR_VL: begin
               if (r.vl_cnt < VL_DEPTH) begin
                  n.vl[r.vl_cnt] = host_data_in;
               end
               n.vl_cnt = r.vl_cnt + 7'h01;
            end
            ADDR_VC: begin
               if (r.vc_cnt < VC_DEPTH) begin
                  n.vc[r.vc_cnt] = host_data_in;
               end
               n.vc_cnt = r.vc_cnt + 8'h01;
            end
            ADDR_CTRL0: n.ctrl0 = host_data_in;
            ADDR_CLR: begin
               n.hl_cnt = '0;
               n.hc_cnt = '0;
               n.vl_cnt = '0;
               n.vc_cnt = '0;
            end
            default: ;
         endcase
      end
      if (rd_start) begin
         n.hd_oe = 1'b1;
         case (host_addr)
            ADDR_HL: begin
               n.hd_out = (r.hl_cnt < HL_DEPTH) ? r.hl[r.hl_cnt] : 8'h00;
               n.hl_cnt = r.hl_cnt + 5'h01;
            end
            ADDR_HC: begin
               n.hd_out = r.hc[r.hc_cnt];
               n.hc_cnt = r.hc_cnt + 4'h1;
            end
            ADDR_VL: begin
               n.hd_out = (r.vl_cnt < VL_DEPTH) ? r.vl[r.vl_cnt] : 8'h00;
               n.vl_cnt = r.vl_cnt + 7'h01;
            end
            ADDR_VC: begin
               n.hd_out = (r.vc_cnt < VC_DEPTH) ? r.vc[r.vc_cnt] : 8'h00;
               n.vc_cnt = r.vc_cnt + 8'h01;
            end
            ADDR_CTRL0: n.hd_out = r.ctrl0;
            default: n.hd_out = 8'h00;
         endcase
      end else if (n.pins[PIN_CS] || n.pins[PIN_RD]) begin
         n.hd_oe = 1'b0;
      end
      n.vl_coef = (vli < VL_DEPTH) ? r.vl[vli] : 8'h00;
      n.vc_coef = (vci < VC_DEPTH) ? r.vc[vci] : 8'h00;
      // Chroma arrives interleaved at half luma rate, one channel per input
      if (accept) begin
         n.yline = {r.yline[TAPS_MAX-2:0], in_y};
         if (r.chan) begin
            n.vline = {r.vline[HC_DEPTH-2:0], in_c};
         end else begin
            n.uline = {r.uline[HC_DEPTH-2:0], in_c};
         end
         n.last_ch = r.chan;
         n.chan = !r.chan;
         n.emit_cnt = '0;
         if (interp) begin
            n.st = CSHF_EMIT;
         end else begin
            n.phase = (r.phase == rlast) ? 2'h0 : r.phase + 2'h1;
            if (r.phase == rlast) begin
               n.st = CSHF_EMIT;
            end
         end
      end
      case (r.st)
         CSHF_EMIT: begin
            // Stalls here while the buffer is full, which holds off the source
            if (wr_if.ready) begin
               if (!interp || r.emit_cnt == rlast) begin
                  n.st = CSHF_ACCEPT;
               end else begin
                  n.emit_cnt = r.emit_cnt + 2'h1;
               end
            end
         end
         CSHF_ACCEPT: ;
         default: n.st = CSHF_ACCEPT;
      endcase
      n.in_ready = (n.st == CSHF_ACCEPT);
      if (rd_if.valid && rd_if.ready) begin
         n.out_valid = 1'b1;
         n.out_word = rd_if.data;
      end else if (out_ready) begin
         n.out_valid = 1'b0;
      end
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         r <= ST_RESET;
      end else begin
         r <= n;
      end
   end
   assign host_data_out = r.hd_out;
   assign host_data_oe = r.hd_oe;
   assign in_ready = r.in_ready;
   assign out_y = r.out_word[FIFO_W-1:PIX_W];
   assign out_c = r.out_word[PIX_W-1:0];
   assign out_valid = r.out_valid;
   assign vl_coef = r.vl_coef;
   assign vc_coef = r.vc_coef;
   assign mode_interp = r.ctrl0[CTRL_INTERP_BIT];
   assign mode_qcif = r.ctrl0[CTRL_QCIF_BIT];
endmodule // cshf_top

// ==== tb/cshf_host_model.sv ====
// Host processor model loading coefficient stores over the strobe bus
module cshf_host_model (
   input wire logic clock,
   output logic [3:0] host_addr,
   output logic [cshf_pkg::PIX_W-1:0] host_data_in,
   output logic host_cs_n,
   output logic host_wr_n,
   output logic host_rd_n,
   input wire logic [cshf_pkg::PIX_W-1:0] host_data_out,
   input wire logic host_data_oe
);
   import cshf_pkg::*;
   initial begin
      {host_addr, host_data_in} = 12'h000;
      {host_cs_n, host_wr_n, host_rd_n} = PINS_IDLE;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      {host_addr, host_data_in, host_cs_n, host_wr_n} <= {a, d, 2'b00};
      // Five edges low clears the three-stage strobe synchroniser
      repeat (5) @(posedge clock);
      {host_data_in, host_cs_n, host_wr_n} <= {~d, 2'b11};
      repeat (5) @(posedge clock);
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      {host_addr, host_cs_n, host_rd_n} <= {a, 2'b00};
      for (int i = 0; i < 12 && host_data_oe !== 1'b1; i++)
         @(negedge clock);
      d = host_data_out;
      @(posedge clock);
      {host_cs_n, host_rd_n} <= 2'b11;
      repeat (5) @(posedge clock);
   endtask
   // Unused slots get zero padding since stores only fill in order
   task automatic load(input logic [3:0] a, input int n, input logic ramp);
      for (int i = 0; i < n; i++)
         wr(a, ramp ? 8'(i + 1) : (i == 0 ? 8'h40 : 8'h00));
   endtask
endmodule // cshf_host_model

// ==== tb/cshf_top_monitor.sv ====
// Port-level assertion checker for the coefficient store and filter
module cshf_top_monitor (
   input wire logic clock,
   input wire logic reset,
   input wire logic host_cs_n,
   input wire logic host_wr_n,
   input wire logic host_rd_n,
   input wire logic [cshf_pkg::PIX_W-1:0] host_data_out,
   input wire logic host_data_oe,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic [cshf_pkg::PIX_W-1:0] out_y,
   input wire logic [cshf_pkg::PIX_W-1:0] out_c,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic mode_interp,
   input wire logic mode_qcif
);
   import cshf_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   a_reset_state: assert property ($fell(reset) |-> !out_valid && !host_data_oe
      && host_data_out == 8'h00 ##[1:2] in_ready) else $error("bad state after reset");
   a_oe_after_rd: assert property ($rose(host_data_oe) |-> !$past(host_rd_n, 2)
      && !$past(host_cs_n, 2)) else $error("data driven without read");
   a_oe_holds: assert property (!host_rd_n && !host_cs_n && host_data_oe |=> host_data_oe)
      else $error("read data dropped early");
   a_oe_release: assert property (host_rd_n [*5] |-> !host_data_oe)
      else $error("data bus not released");
   a_one_set: assert property (in_valid && in_ready && mode_interp |=> !in_ready)
      else $error("ready not dropped");
   a_dec_cif: assert property ((in_valid && in_ready && !mode_interp && !mode_qcif) [*2]
      |=> !in_ready) else $error("cif decimation did not emit");
   a_dec_qcif: assert property ((in_valid && in_ready && !mode_interp && mode_qcif) [*4]
      |=> !in_ready) else $error("qcif decimation did not emit");
   a_cif_burst: assert property (in_valid && in_ready && mode_interp && !mode_qcif
      |=> !in_ready [*2]) else $error("short cif burst");
   a_qcif_burst: assert property (in_valid && in_ready && mode_interp && mode_qcif
      |=> !in_ready [*4]) else $error("short qcif burst");
   a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_y)
      && $stable(out_c)) else $error("output word changed while stalled");
   a_mode_write: assert property (!$stable({mode_interp, mode_qcif}) |->
      !$past(host_wr_n)) else $error("mode changed without write");
   c_qcif_in: cover property (in_valid && in_ready && mode_interp && mode_qcif);
   c_stall: cover property (out_valid && !out_ready);
   c_read: cover property ($rose(host_data_oe));
endmodule // cshf_top_monitor

bind cshf_top cshf_top_monitor i_cshf_top_monitor (.clock(clock), .reset(reset),
   .host_cs_n(host_cs_n), .host_wr_n(host_wr_n), .host_rd_n(host_rd_n),
   .host_data_out(host_data_out), .host_data_oe(host_data_oe), .in_valid(in_valid),
   .in_ready(in_ready), .out_y(out_y), .out_c(out_c), .out_valid(out_valid),
   .out_ready(out_ready), .mode_interp(mode_interp), .mode_qcif(mode_qcif));

// ==== tb/testbench.sv ====
// Self-checking bench for coefficient stores and horizontal filters
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import cshf_pkg::*;
   logic clock = 0;
   logic reset = 1;
   logic [3:0] host_addr;
   logic [PIX_W-1:0] host_drv, host_bus, host_data_out, out_y, out_c, vl_coef, vc_coef;
   logic [PIX_W-1:0] in_y = 8'h00, in_c = 8'h00;
   logic host_data_oe, host_cs_n, host_wr_n, host_rd_n, in_ready, out_valid;
   logic mode_interp, mode_qcif;
   logic in_valid = 0, out_ready = 0, vl_odd = 0, vc_odd = 0;
   logic [4:0] vl_set = 5'h01, vc_set = 5'h01;
   logic [2:0] vl_tap = 3'h0, vc_tap = 3'h0;
   int num_errors = 0;
   int n_tests = 0;
   // Shared data wire: the device wins while it drives
   assign host_bus = host_data_oe ? host_data_out : host_drv;
   always #20 clock = ~clock;
   cshf_top #(.FIFO_DEPTH(FIFO_DEPTH)) i_cshf_top (.clock(clock), .reset(reset),
      .host_addr(host_addr), .host_data_in(host_bus), .host_data_out(host_data_out),
      .host_data_oe(host_data_oe), .host_cs_n(host_cs_n), .host_wr_n(host_wr_n),
      .host_rd_n(host_rd_n), .in_y(in_y), .in_c(in_c), .in_valid(in_valid),
      .in_ready(in_ready), .out_y(out_y), .out_c(out_c), .out_valid(out_valid),
      .out_ready(out_ready), .vl_set(vl_set), .vl_odd(vl_odd), .vl_tap(vl_tap),
      .vl_coef(vl_coef), .vc_set(vc_set), .vc_odd(vc_odd), .vc_tap(vc_tap),
      .vc_coef(vc_coef), .mode_interp(mode_interp), .mode_qcif(mode_qcif));
   cshf_host_model i_cshf_host_model (.clock(clock), .host_addr(host_addr),
      .host_data_in(host_drv), .host_cs_n(host_cs_n), .host_wr_n(host_wr_n),
      .host_rd_n(host_rd_n), .host_data_out(host_data_out), .host_data_oe(host_data_oe));
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task stop_test;
      $display("Counts: %0d mismatches in %0d checks", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic hrd(input logic [3:0] a, input logic [7:0] exp, input string what);
      logic [7:0] d;
      i_cshf_host_model.rd(a, d);
      check(what, 16'(d), 16'(exp));
   endtask
   task automatic test_ctrl;
      for (int m = 0; m < 8; m++) begin
         i_cshf_host_model.wr(ADDR_CTRL0, 8'(m));
         hrd(ADDR_CTRL0, 8'(m), "control");
         check("mode", 16'({mode_qcif, mode_interp}), 16'({m[2], m[0]}));
      end
      hrd(4'h0, 8'h00, "unmapped");
      $display("test_ctrl done");
   endtask
   task automatic look(input logic [7:0] c, input logic [8:0] vq, input logic [8:0] cq,
      input logic [7:0] ev, input logic [7:0] ec);
      i_cshf_host_model.wr(ADDR_CTRL0, c);
      {vl_set, vl_odd, vl_tap, vc_set, vc_odd, vc_tap} <= {vq, cq};
      repeat (2) @(posedge clock);
      @(negedge clock);
      check("vl coef", 16'(vl_coef), 16'(ev));
      check("vc coef", 16'(vc_coef), 16'(ec));
   endtask
   task automatic test_stores;
      i_cshf_host_model.wr(ADDR_CLR, 8'h00);
      i_cshf_host_model.load(ADDR_VL, VL_DEPTH, 1'b1);
      i_cshf_host_model.load(ADDR_VC, VC_DEPTH, 1'b1);
      i_cshf_host_model.load(ADDR_HL, HL_DEPTH, 1'b0);
      i_cshf_host_model.load(ADDR_HC, HC_DEPTH, 1'b0);
      i_cshf_host_model.wr(ADDR_CLR, 8'h00);
      hrd(ADDR_VL, 8'h01, "vl first");
      hrd(ADDR_VL, 8'h02, "vl next");
      hrd(ADDR_HC, 8'h40, "hc first");
      hrd(ADDR_VC, 8'h01, "vc first");
      look(8'h02, {5'd6, 4'd4}, {5'd3, 4'd4}, 8'd30, 8'd15);
      look(8'h06, {5'd6, 4'd6}, {5'd3, 4'd6}, 8'd42, 8'd21);
      look(8'h01, {5'd1, 4'd8}, {5'd1, 4'd8}, 8'd6, 8'd11);
      look(8'h03, {5'd1, 4'd8}, {5'd1, 4'd8}, 8'd6, 8'd31);
      look(8'h03, {5'd1, 4'd0}, {5'd2, 4'd8}, 8'd1, 8'd41);
      look(8'h03, {5'd1, 4'd0}, {5'd5, 4'd4}, 8'd1, 8'd25);
      look(8'h07, {5'd1, 4'd8}, {5'd10, 4'd14}, 8'd15, 8'd140);
      $display("test_stores done");
   endtask
   task automatic run_stream(input logic [7:0] c, input int n, input int r, input logic ip);
      int fed = 0;
      int w = 0;
      int k = 0;
      i_cshf_host_model.wr(ADDR_CTRL0, c);
      {in_valid, in_y, in_c} <= {1'b1, 8'h64, 8'h64};
      while (fed < n && w < 40) begin
         @(negedge clock);
         w++;
         if (in_ready === 1'b1) begin
            fed++;
            w = 0;
         end
      end
      @(posedge clock);
      {in_valid, in_y, in_c} <= {1'b0, 8'h9B, 8'h9B};
      repeat (10) @(posedge clock);
      out_ready <= 1'b1;
      w = 0;
      while (w < 30) begin
         @(negedge clock);
         w++;
         if (out_valid === 1'b1) begin
            check("word", {out_y, out_c}, (!ip || k % r == 0) ? 16'h3232 : 16'h0000);
            k++;
            w = 0;
         end
      end
      @(posedge clock);
      out_ready <= 1'b0;
      check("taken", 16'(fed == n), 16'(n * (ip ? r : 1) <= FIFO_DEPTH));
      check("words", 16'(k), 16'(ip ? fed * r : fed / r));
   endtask
   task automatic test_decimate;
      run_stream(8'h00, 8, 2, 1'b0);
      run_stream(8'h04, 8, 4, 1'b0);
      $display("test_decimate done");
   endtask
   task automatic test_interp;
      run_stream(8'h01, 4, 2, 1'b1);
      run_stream(8'h05, 4, 4, 1'b1);
      $display("test_interp done");
   endtask
   task automatic test_fill;
      // Sink stalls so the buffer fills and input is refused
      run_stream(8'h05, 12, 4, 1'b1);
      $display("test_fill done");
   endtask
   initial begin
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      test_ctrl;
      test_stores;
      test_decimate;
      test_interp;
      test_fill;
      stop_test;
   end
   initial begin
      #400us;
      num_errors++;
      stop_test;
   end
endmodule // testbench
